// ---- src/tfi_pkg.sv ----
// Contract
// (RULE1) 32-bit read-only feature word
// (RULE2) stream table levels: linear or two-level
// (RULE3) terminate model: flag-selected or always abort
// (RULE4) stall field: both, none, forced, reserved
// (RULE5) secure copy mirrored; disable forces no-stall
// (RULE6) pci system never reports forced stall
// (RULE7) ats error recording zero without ats
// (RULE8) walk endianness: mixed, little, big
// (RULE9) mixed endian recommended by default
// (RULE10) virtual ops page needs ops, both stages
// (RULE11) two-level context table support bit
// (RULE12) wide vm identifier support bit
// (RULE13) wildcard bit zero without stage 2
// (RULE14) page request bit zero without ats
// (RULE15) translation ops bit gates virtual page
// (RULE16) wake event support bit
// (RULE17) message interrupts bit, zero if wired only
// (RULE18) bit 10 reports ats support
// (RULE19) bit 1 reports stage 1 support
// (RULE20) bit 0 reports stage 2 support
// (RULE21) read-only; writes ignored; fixed parameters
package tfi_pkg;
  localparam logic [7:0] ADDR_FEATURES_ID0 = 8'h00;
  localparam logic [7:0] ADDR_SEC_STALL_CFG = 8'h04;
  localparam int POS_STLEVEL = 27;
  localparam int POS_TERM = 26;
  localparam int POS_STALL = 24;
  localparam int POS_ATSREC = 23;
  localparam int POS_ENDIAN = 21;
  localparam int POS_VOPS = 20;
  localparam int POS_TWO_LEVEL_CONTEXT_TABLE = 19;
  localparam int POS_WIDE_VM_IDENTIFIER = 18;
  localparam int POS_VMW = 17;
  localparam int POS_PRI = 16;
  localparam int POS_OPS = 15;
  localparam int POS_WAKE = 14;
  localparam int POS_MSI = 13;
  localparam int POS_ATS = 10;
  localparam int POS_S1 = 1;
  localparam int POS_S2 = 0;
  localparam logic [1:0] STALL_BOTH = 2'h0;
  localparam logic [1:0] STALL_NONE = 2'h1;
  localparam logic [1:0] STALL_FORCED = 2'h2;
  localparam logic [1:0] STALL_RSVD = 2'h3;
  localparam logic [1:0] ENDIAN_MIXED = 2'h0;
  localparam logic [1:0] ENDIAN_RSVD = 2'h1;
  localparam logic [1:0] STLEVEL_RSVD_MSB = 2'h2;
  localparam logic [3:0] SEC_CFG_RESET = 4'h0;
endpackage

// ---- src/tfi_bus_if.sv ----
`timescale 1ns/1ps
interface tfi_bus_if;
  logic sel;
  logic we;
  logic [7:0] adr;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  modport slave(input sel, input we, input adr, input dat_w, output dat_r);
  modport master(output sel, output we, output adr, output dat_w, input dat_r);
endinterface

// ---- src/tfi_feature_word.sv ----
`timescale 1ns/1ps
module tfi_feature_word #(
  parameter logic [1:0] STREAM_LEVELS = 2'h1,
  parameter bit TERM_ALWAYS_ABORT = 1'b0,
  parameter logic [1:0] STALL_SUPPORT = 2'h0,
  parameter bit PCI_SYSTEM = 1'b1,
  parameter bit ATS_PRESENT = 1'b1,
  parameter bit ATS_ERR_REC = 1'b1,
  parameter logic [1:0] WALK_ENDIAN = 2'h0,
  parameter bit VIRT_OPS_PAGE = 1'b1,
  parameter bit TWO_LEVEL_CTX = 1'b1,
  parameter bit WIDE_VMID = 1'b1,
  parameter bit VMID_WILDCARD = 1'b1,
  parameter bit PAGE_REQUEST = 1'b1,
  parameter bit TRANS_OPS = 1'b1,
  parameter bit WAKE_EVENTS = 1'b0,
  parameter bit MSI_PRESENT = 1'b1,
  parameter bit STAGE1 = 1'b1,
  parameter bit STAGE2 = 1'b1
) (
  input wire logic secure_state_present_i,
  input wire logic [1:0] secure_stall_model_i,
  input wire logic nonsecure_stall_disable_i,
  output logic [31:0] word_o
);
  logic [1:0] ns_stall;
  logic [1:0] stall_raw;
  logic [1:0] stlev;
  logic [1:0] endian;
  always_comb begin
    stall_raw = STALL_SUPPORT;
    // (RULE5) secure mirror rule
    if (secure_state_present_i) begin
      if (secure_stall_model_i == tfi_pkg::STALL_BOTH && nonsecure_stall_disable_i) begin
        stall_raw = tfi_pkg::STALL_NONE;
      end else begin
        stall_raw = secure_stall_model_i;
      end
    end
    // (RULE4) reserved code downgraded
    ns_stall = (stall_raw == tfi_pkg::STALL_RSVD) ? tfi_pkg::STALL_NONE : stall_raw;
    // (RULE6) pci forbids forced
    if (PCI_SYSTEM && ns_stall == tfi_pkg::STALL_FORCED) begin
      ns_stall = tfi_pkg::STALL_BOTH;
    end
    // (RULE2) reserved levels fall back to linear
    stlev = (STREAM_LEVELS >= tfi_pkg::STLEVEL_RSVD_MSB) ? 2'h0 : STREAM_LEVELS;
    // (RULE8) (RULE9) reserved endian treated as mixed
    endian = (WALK_ENDIAN == tfi_pkg::ENDIAN_RSVD) ? tfi_pkg::ENDIAN_MIXED : WALK_ENDIAN;
    word_o = 32'h0;
    // (RULE1) assemble word
    word_o[tfi_pkg::POS_STLEVEL +: 2] = stlev;
    // (RULE3) terminate model
    word_o[tfi_pkg::POS_TERM] = TERM_ALWAYS_ABORT;
    word_o[tfi_pkg::POS_STALL +: 2] = ns_stall;
    // (RULE7) gated by ats
    word_o[tfi_pkg::POS_ATSREC] = ATS_ERR_REC & ATS_PRESENT;
    word_o[tfi_pkg::POS_ENDIAN +: 2] = endian;
    // (RULE10) (RULE15) virtual page dependency
    word_o[tfi_pkg::POS_VOPS] = VIRT_OPS_PAGE & TRANS_OPS & STAGE1 & STAGE2;
    // (RULE11) two-level context
    word_o[tfi_pkg::POS_TWO_LEVEL_CONTEXT_TABLE] = TWO_LEVEL_CTX;
    // (RULE12) wide vmid
    word_o[tfi_pkg::POS_WIDE_VM_IDENTIFIER] = WIDE_VMID;
    // (RULE13) wildcard needs stage 2
    word_o[tfi_pkg::POS_VMW] = VMID_WILDCARD & STAGE2;
    // (RULE14) page request needs ats
    word_o[tfi_pkg::POS_PRI] = PAGE_REQUEST & ATS_PRESENT;
    word_o[tfi_pkg::POS_OPS] = TRANS_OPS;
    // (RULE16) wake events
    word_o[tfi_pkg::POS_WAKE] = WAKE_EVENTS;
    // (RULE17) message interrupts
    word_o[tfi_pkg::POS_MSI] = MSI_PRESENT;
    // (RULE18) ats bit
    word_o[tfi_pkg::POS_ATS] = ATS_PRESENT;
    // (RULE19) stage 1 bit
    word_o[tfi_pkg::POS_S1] = STAGE1;
    // (RULE20) stage 2 bit
    word_o[tfi_pkg::POS_S2] = STAGE2;
  end
endmodule

// ---- src/tfi_regs.sv ----
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module tfi_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  tfi_bus_if bus ();
  logic [31:0] feat_word;
  logic [3:0] sec_cfg;
  logic [3:0] next_sec_cfg;
  logic ack;
  logic next_ack;
  logic err;
  logic next_err;
  logic [31:0] rdat;
  logic [31:0] next_rdat;
  logic req;
  logic hit_feat;
  logic hit_sec;

  assign bus.sel = req;
  assign bus.we = wb_we_i;
  assign bus.adr = wb_adr_i;
  assign bus.dat_w = wb_dat_i;
  assign req = wb_cyc_i & wb_stb_i & ~ack & ~err;
  assign hit_feat = (wb_adr_i == tfi_pkg::ADDR_FEATURES_ID0);
  assign hit_sec = (wb_adr_i == tfi_pkg::ADDR_SEC_STALL_CFG);

  // sec_cfg: [0] secure present, [2:1] secure stall model, [3] nonsecure stall disable
  tfi_feature_word u_word (
    .secure_state_present_i(sec_cfg[0]),
    .secure_stall_model_i(sec_cfg[2:1]),
    .nonsecure_stall_disable_i(sec_cfg[3]),
    .word_o(feat_word)
  );

  always_comb begin
    next_sec_cfg = sec_cfg;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_rdat = rdat;
    if (req) begin
      if (hit_feat) begin
        next_ack = 1'b1;
        // (RULE21) writes ignored
        next_rdat = wb_we_i ? 32'h0 : feat_word;
      end else if (hit_sec) begin
        next_ack = 1'b1;
        if (wb_we_i && wb_sel_i[0]) begin
          next_sec_cfg = wb_dat_i[3:0];
        end
        next_rdat = {28'h0, sec_cfg};
      end else begin
        next_err = 1'b1;
        next_rdat = 32'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_cfg <= tfi_pkg::SEC_CFG_RESET;
      ack <= 1'b0;
      err <= 1'b0;
      rdat <= 32'h0;
    end else begin
      sec_cfg <= next_sec_cfg;
      ack <= next_ack;
      err <= next_err;
      rdat <= next_rdat;
    end
  end

  assign wb_ack_o = ack;
  assign wb_err_o = err;
  assign wb_dat_o = rdat;
  assign bus.dat_r = rdat;

  property p_ro;
    @(posedge clk_i) disable iff (rst_i)
      (req && hit_feat && wb_we_i) |=> (feat_word == $past(feat_word));
  endproperty
  a_ro: assert property (p_ro) else $error("feature word changed by write"); // (RULE21)

  property p_read;
    @(posedge clk_i) disable iff (rst_i)
      (req && hit_feat && !wb_we_i) |=> (ack && rdat == $past(feat_word));
  endproperty
  a_read: assert property (p_read) else $error("feature read wrong"); // (RULE1)

  property p_top;
    @(posedge clk_i) disable iff (rst_i) feat_word[31:29] == 3'h0 && !feat_word[28];
  endproperty
  a_top: assert property (p_top) else $error("reserved bits set"); // (RULE2)

  property p_stall;
    @(posedge clk_i) disable iff (rst_i) feat_word[25:24] != tfi_pkg::STALL_FORCED;
  endproperty
  a_stall: assert property (p_stall) else $error("forced stall on pci"); // (RULE6)

  property p_mirror;
    @(posedge clk_i) disable iff (rst_i)
      sec_cfg[0] |-> feat_word[25:24] == sec_cfg[2:1] || sec_cfg[2:1] == tfi_pkg::STALL_RSVD
        || sec_cfg[2:1] == tfi_pkg::STALL_FORCED
        || (sec_cfg[2:1] == tfi_pkg::STALL_BOTH && sec_cfg[3]
          && feat_word[25:24] == tfi_pkg::STALL_NONE);
  endproperty
  a_mirror: assert property (p_mirror) else $error("stall mirror wrong"); // (RULE5)

  property p_vops;
    @(posedge clk_i) disable iff (rst_i) feat_word[20] |-> feat_word[15] && feat_word[1:0] == 2'h3;
  endproperty
  a_vops: assert property (p_vops) else $error("virtual page without deps"); // (RULE10)

  property p_ats;
    @(posedge clk_i) disable iff (rst_i) !feat_word[10] |-> !feat_word[23] && !feat_word[16];
  endproperty
  a_ats: assert property (p_ats) else $error("ats dependent bit set"); // (RULE14)

  property p_vmw;
    @(posedge clk_i) disable iff (rst_i) !feat_word[0] |-> !feat_word[17];
  endproperty
  a_vmw: assert property (p_vmw) else $error("wildcard without stage 2"); // (RULE13)

  property p_unmapped;
    @(posedge clk_i) disable iff (rst_i) (req && !hit_feat && !hit_sec) |=> err && !ack;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not erred"); // (RULE21)

  property p_stall_rsvd;
    @(posedge clk_i) disable iff (rst_i) feat_word[25:24] != tfi_pkg::STALL_RSVD;
  endproperty
  a_stall_rsvd: assert property (p_stall_rsvd) else $error("reserved stall code"); // (RULE4)

  property p_endian;
    @(posedge clk_i) disable iff (rst_i) feat_word[22:21] != tfi_pkg::ENDIAN_RSVD;
  endproperty
  a_endian: assert property (p_endian) else $error("reserved endian code"); // (RULE8)

  property p_nsdis;
    @(posedge clk_i) disable iff (rst_i)
      (sec_cfg[0] && sec_cfg[3] && sec_cfg[2:1] == tfi_pkg::STALL_BOTH)
        |-> feat_word[25:24] == tfi_pkg::STALL_NONE;
  endproperty
  a_nsdis: assert property (p_nsdis) else $error("stall disable ignored"); // (RULE5)
endmodule

// ---- tb/tfi_regs_tb.sv ----
`timescale 1ns/1ps
module tfi_regs_tb;
  localparam logic [31:0] base_word = 32'h089f_a403;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic was_err;
  // secure config writes: bit0 present, bits 2:1 stall model
  logic [3:0] cfg_tab [6] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h4, 4'h9};
  logic [1:0] stall_tab [6] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1};

  always #2.5 clk_i = ~clk_i;

  tfi_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // classic cycle; ack and data sampled at the rising edge where ack is high
  task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] wd,
    input logic [3:0] sel, output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        final_report();
      end
      @(posedge clk_i);
    end
    rdata = wb_dat_o;
    err = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
    // answer is a single-cycle pulse
    check_flag(wb_ack_o | wb_err_o, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    check_word(wb_dat_o, 32'h0);
    check_flag(wb_ack_o | wb_err_o, 1'b0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb_access(1'b0, 8'h00, 32'h0, 4'hf, rd, was_err);
    check_flag(was_err, 1'b0);
    check_word(rd, base_word);
    check_word(rd, base_word);
    // write attempt on the read-only word, with cyc low for two cycles after the read
    wb_access(1'b1, 8'h00, ~base_word, 4'hf, rd, was_err);
    check_flag(was_err, 1'b0);
    wb_access(1'b0, 8'h00, 32'h0, 4'hf, rd, was_err);
    check_word(rd, base_word);
    for (int i = 0; i < 6; i++) begin
      wb_access(1'b1, 8'h04, {28'h0, cfg_tab[i]}, 4'hf, rd, was_err);
      check_flag(was_err, 1'b0);
      wb_access(1'b0, 8'h00, 32'h0, 4'hf, rd, was_err);
      check_word(rd, base_word | {6'h0, stall_tab[i], 24'h0});
    end
    // byte lane 0 disabled: secure config must not change
    wb_access(1'b1, 8'h04, 32'h1, 4'h0, rd, was_err);
    wb_access(1'b0, 8'h00, 32'h0, 4'hf, rd, was_err);
    check_word(rd, base_word | {6'h0, 2'h1, 24'h0});
    wb_access(1'b0, 8'h08, 32'h0, 4'hf, rd, was_err);
    check_flag(was_err, 1'b1);
    wb_access(1'b1, 8'h0c, 32'h1, 4'hf, rd, was_err);
    check_flag(was_err, 1'b1);
    final_report();
  end
endmodule
